/* design/scm_clock_manager.v */
// Purpose: Switching clock manager: main clock, sync in/out, phases, spread spectrum, MCU reset delay
// Assumes: Config ports are on clk domain; external_sync_input and mcu_supply_ok are asynchronous
// Notes:   Converter clocks are square waves; sync_clock_output drives only while its enable is set
//          Removing the reference in sync mode stalls the clocks until loss is detected
//          Spread spectrum acts on the internal oscillator only, not on a locked reference
//          Step-up clock has no phase select and runs with the main clock
// Operation
// R1: Main frequency 1800-2500 kHz, 100 kHz steps
// R2: Converter and sync clocks from one main clock
// R3: External sync off after reset
// R4: Sync needs reference present and software enable
// R5: External clock stays while synchronized
// R6: Frequency change in sync settles quickly
// R7: Sync output follows primary step-down frequency
// R8: Sync output 50% duty, 0 or 180 degrees
// R9: Sync output disabled until software enables
// R10: Phase shift applied per converter clock
// R11: Separate phase selects for three clocks
// R12: Spread spectrum modulates the main clock
// R13: Spread spectrum off until enable bit
// R14: MCU reset held until supply good delay
// R15: Sync disabled ignores the sync input
`timescale 1ns/10ps
`default_nettype none
`include "scm_defines.vh"

module scm_clock_manager #(
	parameter RESDEL0_CYC = `SCM_RESDEL0_US * `SCM_CLK_MHZ,
	parameter RESDEL1_CYC = `SCM_RESDEL1_US * `SCM_CLK_MHZ,
	parameter RESDEL2_CYC = `SCM_RESDEL2_US * `SCM_CLK_MHZ,
	parameter RESDEL3_CYC = `SCM_RESDEL3_US * `SCM_CLK_MHZ,
	parameter SSM_DWELL   = `SCM_SSM_DWELL_CYC
) (
	input  wire       clk,
	input  wire       reset,
	input  wire [2:0] main_freq_config,
	input  wire       sync_enable,
	input  wire       sync_out_enable,
	input  wire       primary_phase_sel,
	input  wire       secondary_phase_sel,
	input  wire       sync_out_phase_sel,
	input  wire       spread_spectrum_enable,
	input  wire [1:0] reset_release_delay,
	input  wire       mcu_supply_ok,
	input  wire       external_sync_input,
	output reg        primary_step_down_clk_q,
	output reg        secondary_step_down_clk_q,
	output reg        step_up_converter_clk_q,
	output reg        sync_clock_output_q,
	output reg        sync_clock_output_oe_q,
	output reg        sync_active_q,
	output reg        mcu_reset_output_n_q
);

	// Accumulator increment for a frequency in kHz
	function [31:0] nco_inc;
		input [11:0] khz;
		begin
			nco_inc = {20'h0_0000, khz} * `SCM_NCO_PER_KHZ;
		end
	endfunction

	reg  [1:0]  sync_in_q;
	reg  [1:0]  supply_q;
	reg         sync_prev_q;
	reg  [7:0]  sync_gap_q;
	reg  [7:0]  sync_period_q;
	reg  [7:0]  sync_phase_q;
	reg         ref_present_q;
	reg  [31:0] nco_q;
	reg  [2:0]  ssm_slot_q;
	reg  [19:0] ssm_dwell_q;
	reg  [19:0] reset_release_delay_cnt_q;
	reg  [11:0] base_khz;
	reg  [11:0] ssm_mag;
	reg  [15:0] ssm_wide;
	reg  [11:0] fmain_khz;
	reg  [19:0] reset_release_delay_lim;
	reg         main_clk;
	wire        sync_rise;

	// Loss limit cut to the width of the gap counter
	localparam [31:0] SYNC_LOSS_FULL = `SCM_SYNC_LOSS_CYC - 1;
	localparam [7:0]  SYNC_LOSS_LIM  = SYNC_LOSS_FULL[7:0];

	// Two-stage synchronisers for the asynchronous inputs
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_in_q <= 2'h0;
			supply_q  <= 2'h0;
		end else begin
			sync_in_q <= {sync_in_q[0], external_sync_input};
			supply_q  <= {supply_q[0], mcu_supply_ok};
		end
	end

	assign sync_rise = sync_in_q[1] & ~sync_prev_q;

	// Main frequency with spread-spectrum offset in 3.75% units
	always @* begin
		base_khz  = `SCM_FMAIN_MIN_KHZ + ({9'h000, main_freq_config} * `SCM_FMAIN_STEP_KHZ); // R1
		ssm_wide  = ({4'h0, base_khz} * `SCM_SSM_STEP_NUM) / `SCM_SSM_STEP_DEN; // Wide product, no overflow
		ssm_mag   = ssm_wide[11:0];
		fmain_khz = base_khz;
		if (spread_spectrum_enable) begin // R13
			case (ssm_slot_q) // R12
				3'h1, 3'h3: fmain_khz = base_khz + ssm_mag;
				3'h2:       fmain_khz = base_khz + (ssm_mag << 1);
				3'h5, 3'h7: fmain_khz = base_khz - ssm_mag;
				3'h6:       fmain_khz = base_khz - (ssm_mag << 1);
				default:    fmain_khz = base_khz;
			endcase
		end
	end

	// Spread-spectrum triangle stepping, parked at centre when off
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ssm_slot_q  <= 3'h0;
			ssm_dwell_q <= 20'h0_0000;
		end else if (!spread_spectrum_enable) begin // R13
			ssm_slot_q  <= 3'h0;
			ssm_dwell_q <= 20'h0_0000;
		end else if (ssm_dwell_q == SSM_DWELL[19:0] - 20'h0_0001) begin
			ssm_slot_q  <= ssm_slot_q + 3'h1;
			ssm_dwell_q <= 20'h0_0000;
		end else begin
			ssm_dwell_q <= ssm_dwell_q + 20'h0_0001;
		end
	end

	// Reference detection and period measurement on the sync input
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_prev_q   <= 1'b0;
			sync_gap_q    <= 8'h00;
			sync_period_q <= 8'h00;
			sync_phase_q  <= 8'h00;
			ref_present_q <= 1'b0;
		end else begin
			sync_prev_q <= sync_in_q[1];
			if (sync_rise) begin
				sync_period_q <= sync_gap_q + 8'h01;
				sync_gap_q    <= 8'h00;
				sync_phase_q  <= 8'h00; // Realign phase on each rising reference edge
				ref_present_q <= 1'b1;
			end else if (sync_gap_q == SYNC_LOSS_LIM) begin
				ref_present_q <= 1'b0; // Reference lost
			end else begin
				sync_gap_q   <= sync_gap_q + 8'h01;
				sync_phase_q <= sync_phase_q + 8'h01;
			end
		end
	end

	// Sync mode needs both the enable and a live reference
	always @(posedge clk or posedge reset) begin
		if (reset)
			sync_active_q <= 1'b0; // R3
		else
			sync_active_q <= sync_enable & ref_present_q; // R4 R15 R5
	end

	// Internal oscillator accumulator
	always @(posedge clk or posedge reset) begin
		if (reset)
			nco_q <= 32'h0000_0000;
		else
			nco_q <= nco_q + nco_inc(fmain_khz); // R1
	end

	// Single main clock: internal or rebuilt 50% from the reference
	always @* begin
		if (sync_active_q)
			main_clk = sync_phase_q < {1'b0, sync_period_q[7:1]}; // R6
		else
			main_clk = nco_q[31]; // R15
	end

	// Converter and sync clocks, phase select on each except the step-up clock
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			primary_step_down_clk_q   <= 1'b0;
			secondary_step_down_clk_q <= 1'b0;
			step_up_converter_clk_q   <= 1'b0;
			sync_clock_output_q       <= 1'b0;
			sync_clock_output_oe_q    <= 1'b0;
		end else begin
			primary_step_down_clk_q   <= main_clk ^ primary_phase_sel; // R2 R10 R11
			secondary_step_down_clk_q <= main_clk ^ secondary_phase_sel; // R11
			step_up_converter_clk_q   <= main_clk; // Step-up follows the main clock, no phase select R10
			sync_clock_output_q       <= sync_out_enable & (main_clk ^ sync_out_phase_sel); // R7 R8
			sync_clock_output_oe_q    <= sync_out_enable; // R9
		end
	end

	// Selected reset release delay
	always @* begin
		case (reset_release_delay)
			2'h0:    reset_release_delay_lim = RESDEL0_CYC[19:0];
			2'h1:    reset_release_delay_lim = RESDEL1_CYC[19:0];
			2'h2:    reset_release_delay_lim = RESDEL2_CYC[19:0];
			default: reset_release_delay_lim = RESDEL3_CYC[19:0];
		endcase
	end

	// MCU reset held low until supply good for the delay
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			reset_release_delay_cnt_q         <= 20'h0_0000;
			mcu_reset_output_n_q <= 1'b0;
		end else if (!supply_q[1]) begin
			reset_release_delay_cnt_q         <= 20'h0_0000;
			mcu_reset_output_n_q <= 1'b0; // R14
		end else if (reset_release_delay_cnt_q >= reset_release_delay_lim) begin
			mcu_reset_output_n_q <= 1'b1; // R14
		end else begin
			reset_release_delay_cnt_q <= reset_release_delay_cnt_q + 20'h0_0001;
		end
	end

endmodule
`default_nettype wire

/* design/scm_defines.vh */
// Purpose: Shared constants of the switching clock manager
// Assumes: 100 MHz system clock
// Notes:   Times in their own unit, cycle counts derived from them
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH

// System clock rate
`define SCM_CLK_MHZ            100
// Main frequency range and step, kHz
`define SCM_FMAIN_MIN_KHZ      12'h0_708
`define SCM_FMAIN_STEP_KHZ     12'h0_064
`define SCM_FMAIN_NOM_CODE     3'h4
// Accumulator increment per kHz: 2^32 / 100000 kHz, rounded
`define SCM_NCO_PER_KHZ        32'h0000_A7C6
// Spread spectrum: modulation frequency 9 kHz, 8 dwell slots per period
`define SCM_SSM_FREQ_KHZ       9
`define SCM_SSM_DWELL_CYC      ((`SCM_CLK_MHZ * 1000) / (`SCM_SSM_FREQ_KHZ * 8))
// Spread step 3.75% of the base frequency as a ratio
`define SCM_SSM_STEP_NUM       16'h0003
`define SCM_SSM_STEP_DEN       16'h0050
// External reference lost after 2 us without a rising edge
`define SCM_SYNC_LOSS_NS       2000
`define SCM_SYNC_LOSS_CYC      (`SCM_SYNC_LOSS_NS * `SCM_CLK_MHZ / 1000)
// Reset release delays, us, one per selection code
`define SCM_RESDEL0_US         200
`define SCM_RESDEL1_US         400
`define SCM_RESDEL2_US         800
`define SCM_RESDEL3_US         1600

`endif

/* test/scm_props.sv */
// Purpose: Port checks of the clock manager
// Assumes: One clk domain
// Notes:   Bound to scm_clock_manager
`timescale 1ns/10ps
`default_nettype none
module scm_props_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic sync_enable,
	input wire logic sync_out_enable,
	input wire logic primary_phase_sel,
	input wire logic secondary_phase_sel,
	input wire logic sync_out_phase_sel,
	input wire logic mcu_supply_ok,
	input wire logic primary_step_down_clk_q,
	input wire logic secondary_step_down_clk_q,
	input wire logic step_up_converter_clk_q,
	input wire logic sync_clock_output_q,
	input wire logic sync_clock_output_oe_q,
	input wire logic sync_active_q,
	input wire logic mcu_reset_output_n_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Phase relations of the three derived clocks
	sec_phase_a: assert property ($stable({primary_phase_sel, secondary_phase_sel}) |->
		(secondary_step_down_clk_q ^ secondary_phase_sel) == (primary_step_down_clk_q ^ primary_phase_sel))
		else $error("secondary phase wrong");
	boost_phase_a: assert property ($stable(primary_phase_sel) |->
		step_up_converter_clk_q == (primary_step_down_clk_q ^ primary_phase_sel)) else $error("boost phase wrong");
	sync_phase_a: assert property (sync_clock_output_oe_q && $stable({primary_phase_sel, sync_out_phase_sel}) |->
		(sync_clock_output_q ^ sync_out_phase_sel) == (primary_step_down_clk_q ^ primary_phase_sel))
		else $error("sync out phase wrong");
	// Output off while disabled, lock gated by enable, main clock alive
	out_off_a: assert property (!sync_out_enable [*2] |-> !sync_clock_output_oe_q && !sync_clock_output_q)
		else $error("sync out driven");
	sync_gate_a: assert property (!$past(sync_enable) |-> !sync_active_q) else $error("lock while off");
	clk_alive_a: assert property ($changed(primary_step_down_clk_q) |-> ##[1:40] $changed(primary_step_down_clk_q))
		else $error("main clock stalled");
	// Reset output against supply state
	rst_hold_a: assert property (!mcu_supply_ok [*3] |=> !mcu_reset_output_n_q) else $error("reset not held");
	rst_rel_a: assert property ($rose(mcu_reset_output_n_q) |-> $past(mcu_supply_ok, 3) && $past(mcu_supply_ok, 8))
		else $error("early release");
	cover property ($rose(sync_active_q));
	cover property ($rose(mcu_reset_output_n_q));
	cover property ($rose(sync_clock_output_oe_q));
	cover property ($fell(sync_clock_output_oe_q));
endmodule
bind scm_clock_manager scm_props_chk p (
	.clk                       (clk),
	.reset                     (reset),
	.sync_enable               (sync_enable),
	.sync_out_enable           (sync_out_enable),
	.primary_phase_sel         (primary_phase_sel),
	.secondary_phase_sel       (secondary_phase_sel),
	.sync_out_phase_sel        (sync_out_phase_sel),
	.mcu_supply_ok             (mcu_supply_ok),
	.primary_step_down_clk_q   (primary_step_down_clk_q),
	.secondary_step_down_clk_q (secondary_step_down_clk_q),
	.step_up_converter_clk_q   (step_up_converter_clk_q),
	.sync_clock_output_q       (sync_clock_output_q),
	.sync_clock_output_oe_q    (sync_clock_output_oe_q),
	.sync_active_q             (sync_active_q),
	.mcu_reset_output_n_q      (mcu_reset_output_n_q)
);
`default_nettype wire

/* test/scm_sync_src.sv */
// Purpose: External reference clock
// Assumes: 125 ns period
// Notes:   Stands low outside bursts
`timescale 1ns/10ps
`default_nettype none
module scm_sync_src (
	input  wire logic run,
	output var logic  ref_clk
);
	// Unbroken square wave while run is high
	initial ref_clk = 1'h0;
	always begin
		wait (run);
		#62.5 ref_clk = 1'h1;
		#62.5 ref_clk = 1'h0;
	end
endmodule
`default_nettype wire

/* test/switching_clock_manager_bench.sv */
// Purpose: Self-checking bench of the clock manager
// Assumes: Small delay and dwell parameters
// Notes:   Periods counted in clk cycles
`timescale 1ns/10ps
`default_nettype none
module switching_clock_manager_bench;
	logic       clk, reset, sync_enable, sync_out_enable, primary_phase_sel, secondary_phase_sel, run;
	logic       sync_out_phase_sel, spread_spectrum_enable, mcu_supply_ok;
	logic [2:0] main_freq_config;
	logic [1:0] reset_release_delay;
	wire logic  external_sync_input, primary_step_down_clk_q, secondary_step_down_clk_q, step_up_converter_clk_q;
	wire logic  sync_clock_output_q, sync_clock_output_oe_q, sync_active_q, mcu_reset_output_n_q;
	int         fail_count = 0, tests_run = 0, cyc = 0;
	scm_clock_manager #(.RESDEL0_CYC(20), .RESDEL1_CYC(40), .RESDEL2_CYC(80), .RESDEL3_CYC(160), .SSM_DWELL(200)) uut (
		.clk                       (clk),
		.reset                     (reset),
		.main_freq_config          (main_freq_config),
		.sync_enable               (sync_enable),
		.sync_out_enable           (sync_out_enable),
		.primary_phase_sel         (primary_phase_sel),
		.secondary_phase_sel       (secondary_phase_sel),
		.sync_out_phase_sel        (sync_out_phase_sel),
		.spread_spectrum_enable    (spread_spectrum_enable),
		.reset_release_delay       (reset_release_delay),
		.mcu_supply_ok             (mcu_supply_ok),
		.external_sync_input       (external_sync_input),
		.primary_step_down_clk_q   (primary_step_down_clk_q),
		.secondary_step_down_clk_q (secondary_step_down_clk_q),
		.step_up_converter_clk_q   (step_up_converter_clk_q),
		.sync_clock_output_q       (sync_clock_output_q),
		.sync_clock_output_oe_q    (sync_clock_output_oe_q),
		.sync_active_q             (sync_active_q),
		.mcu_reset_output_n_q      (mcu_reset_output_n_q)
	);
	scm_sync_src src (.run(run), .ref_clk(external_sync_input));
	// Clock and cycle count
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Cycles over n primary periods
	task automatic per(input int n, output int c);
		int e, t0, k;
		logic p;
		e = -1;
		k = 0;
		p = primary_step_down_clk_q;
		while (e < n) begin
			w(1);
			k++;
			if (k > 8000) begin
				fail_count++;
				end_sim;
			end
			if (primary_step_down_clk_q && !p) e++;
			if (e == 0 && k > 0 && primary_step_down_clk_q && !p) t0 = cyc;
			p = primary_step_down_clk_q;
		end
		c = cyc - t0;
	endtask
	task automatic t_rst;
		int k;
		for (int d = 0; d < 4; d++) begin
			reset_release_delay = d[1:0];
			mcu_supply_ok = 1'h1;
			for (k = 0; k < 300 && mcu_reset_output_n_q !== 1'h1; k++) w(1);
			chk(k >= (20 << d) && k <= (20 << d) + 5, 1);
			if (k == 300) end_sim;
			mcu_supply_ok = 1'h0;
			w(5);
			chk(mcu_reset_output_n_q, 0);
		end
	endtask
	task automatic t_freq;
		int c;
		for (int n = 0; n < 8; n++) begin
			main_freq_config = n[2:0];
			per(1, c);
			per(10, c);
			chk(c * (1800 + 100 * n) >= 990000 && c * (1800 + 100 * n) <= 1010000, 1);
		end
	endtask
	task automatic t_sync;
		int c, k;
		sync_enable = 1'h1;
		w(40);
		chk(sync_active_q, 0);
		run = 1'h1;
		for (k = 0; k < 100 && sync_active_q !== 1'h1; k++) w(1);
		chk(sync_active_q, 1);
		if (k == 100) end_sim;
		per(2, c);
		per(8, c);
		chk(c >= 98 && c <= 102, 1);
		sync_enable = 1'h0;
		w(3);
		chk(sync_active_q, 0);
		per(2, c);
		per(10, c);
		chk(c >= 396 && c <= 404, 1);
		run = 1'h0;
	endtask
	task automatic t_out;
		int h;
		logic m;
		chk(sync_clock_output_oe_q, 0);
		for (int ph = 0; ph < 2; ph++) begin
			sync_out_enable = 1'h1;
			{primary_phase_sel, secondary_phase_sel, sync_out_phase_sel} = ph[0] ? 3'h6 : 3'h3;
			w(2);
			chk(sync_clock_output_oe_q, 1);
			h = 0;
			repeat (400) begin
				w(1);
				h += sync_clock_output_q;
				m = primary_step_down_clk_q ^ primary_phase_sel;
				chk({secondary_step_down_clk_q ^ secondary_phase_sel, step_up_converter_clk_q}, {m, m});
				chk(sync_clock_output_q ^ sync_out_phase_sel, m);
			end
			chk(h >= 190 && h <= 210, 1);
		end
		sync_out_enable = 1'h0;
		w(2);
		chk({sync_clock_output_oe_q, sync_clock_output_q}, 0);
	endtask
	task automatic t_ssm;
		int c, lo, hi;
		for (int s = 0; s < 2; s++) begin
			spread_spectrum_enable = s[0];
			lo = 999;
			hi = 0;
			repeat (48) begin
				per(1, c);
				if (c < lo) lo = c;
				if (c > hi) hi = c;
			end
			chk(hi - lo > 2, s[0]);
		end
	endtask
	// Main sequence
	initial begin
		{reset, sync_enable, sync_out_enable, primary_phase_sel, secondary_phase_sel, run} = 6'h20;
		{sync_out_phase_sel, spread_spectrum_enable, mcu_supply_ok} = 3'h0;
		main_freq_config = 3'h4;
		reset_release_delay = 2'h0;
		reset = 1'h1;
		w(4);
		reset = 1'h0;
		w(2);
		chk({sync_active_q, sync_clock_output_oe_q, mcu_reset_output_n_q}, 0);
		t_rst;
		t_freq;
		t_sync;
		t_out;
		t_ssm;
		end_sim;
	end
endmodule
`default_nettype wire
